// [include/ebsw_pkg.sv]
// Purpose: Shared constants, types and wait-code decoding for the external bus control block
// Assumes: Bus clock cycles are counted on the bus clock bclk
// Notes: Wait-code tables pair one code with one cycle count by position
package ebsw_pkg;

  localparam int unsigned EBSW_AREAS = 4;
  localparam int unsigned EBSW_ADDR_W = 24;
  localparam int unsigned EBSW_CODE_W = 5;
  localparam int unsigned EBSW_CNT_W = 4;
  localparam int unsigned EBSW_PIN_W = 4;
  localparam int unsigned EBSW_LOW_ADDR_W = EBSW_ADDR_W - EBSW_PIN_W;

  typedef enum logic [1:0] {EBSW_KIND_RAM, EBSW_KIND_SFR, EBSW_KIND_EXT} ebsw_kind_t;

  // Area select layout: how many selects replace the top address pins
  localparam logic [1:0] EBSW_ACFG_NONE = 2'h0;
  localparam logic [1:0] EBSW_ACFG_ONE = 2'h1;
  localparam logic [1:0] EBSW_ACFG_TWO = 2'h2;
  localparam logic [1:0] EBSW_ACFG_FOUR = 2'h3;
  localparam logic [2:0] EBSW_SEL_NONE = 3'h0;
  localparam logic [2:0] EBSW_SEL_ONE = 3'h1;
  localparam logic [2:0] EBSW_SEL_TWO = 3'h2;
  localparam logic [2:0] EBSW_SEL_FOUR = 3'h4;

  // Internal space cycle lengths and the nine-cycle external length, in bus clocks
  localparam logic [EBSW_CNT_W-1:0] EBSW_RAM_CYC = 4'h1;
  localparam logic [EBSW_CNT_W-1:0] EBSW_RAM_WAIT_CYC = 4'h2;
  localparam logic [EBSW_CNT_W-1:0] EBSW_SFR_CYC = 4'h2;
  localparam logic [EBSW_CNT_W-1:0] EBSW_SFR_WAIT_CYC = 4'h3;
  localparam logic [EBSW_CNT_W-1:0] EBSW_NINE_CYC = 4'h9;
  // Reserved codes run the longest cycle so slow devices are never cut short
  localparam logic [EBSW_CNT_W-1:0] EBSW_RSV_CYC = 4'h9;
  localparam logic [EBSW_CNT_W-1:0] EBSW_ONE_CYC = 4'h1;

  localparam int unsigned EBSW_SEP_N = 11;
  localparam int unsigned EBSW_MUX_N = 7;
  localparam logic [EBSW_CODE_W-1:0] EBSW_SEP_CODE [EBSW_SEP_N] = '{
    5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0a, 5'h0b, 5'h0c, 5'h13, 5'h14};
  localparam logic [EBSW_CNT_W-1:0] EBSW_SEP_CYC [EBSW_SEP_N] = '{
    4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h4, 4'h5, 4'h6, 4'h6, 4'h7};
  localparam logic [EBSW_CODE_W-1:0] EBSW_MUX_CODE [EBSW_MUX_N] = '{
    5'h0a, 5'h0b, 5'h0d, 5'h13, 5'h14, 5'h15, 5'h16};
  localparam logic [EBSW_CNT_W-1:0] EBSW_MUX_CYC [EBSW_MUX_N] = '{
    4'h4, 4'h5, 4'h7, 4'h6, 4'h7, 4'h8, 4'h9};

  // Returns {reserved, cycle count}
  function automatic logic [EBSW_CNT_W:0] ebsw_wait_decode(
    input logic [EBSW_CODE_W-1:0] code,
    input logic mux,
    input logic [EBSW_CODE_W-1:0] nine_code
  );
    logic [EBSW_CNT_W:0] res;
    res = {1'b1, EBSW_RSV_CYC};
    if (mux)
    begin
      for (int i = 0; i < EBSW_MUX_N; i++)
        if (code == EBSW_MUX_CODE[i])
          res = {1'b0, EBSW_MUX_CYC[i]};
    end
    else
    begin
      if (code == nine_code)
        res = {1'b0, EBSW_NINE_CYC};
      for (int i = 0; i < EBSW_SEP_N; i++)
        if (code == EBSW_SEP_CODE[i])
          res = {1'b0, EBSW_SEP_CYC[i]};
    end
    return res;
  endfunction : ebsw_wait_decode

  function automatic logic [2:0] ebsw_sel_count(input logic [1:0] acfg);
    logic [2:0] n;
    n = EBSW_SEL_NONE;
    unique case (acfg)
      EBSW_ACFG_NONE: n = EBSW_SEL_NONE;
      EBSW_ACFG_ONE: n = EBSW_SEL_ONE;
      EBSW_ACFG_TWO: n = EBSW_SEL_TWO;
      EBSW_ACFG_FOUR: n = EBSW_SEL_FOUR;
    endcase
    return n;
  endfunction : ebsw_sel_count

endpackage : ebsw_pkg

// [src/ebsw_sync.sv]
// Purpose: Two-flop synchroniser for levels and toggles entering a clock domain
// Assumes: Multi-bit use only for quasi-static values or values held under a handshake
// Notes: The first stage feeds nothing but the second stage
`timescale 1ns/100ps
`default_nettype none
module ebsw_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } ebsw_sync_t;

  ebsw_sync_t s_q;
  ebsw_sync_t s_d;

  always_comb
  begin
    s_d.meta = din;
    s_d.held = s_q.meta;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign dout = s_q.held;

endmodule : ebsw_sync
`default_nettype wire

// [src/ebsw_ctrl.sv]
// Purpose: External bus area selects, read/write strobes and bus cycle lengths
// Assumes: Requests arrive on ref_clk; the external cycle runs on the bus clock bclk
// Notes: Configuration ports are quasi-static and only change between accesses
`timescale 1ns/100ps
`default_nettype none
module ebsw_ctrl #(
  parameter int unsigned NUM_AREAS = ebsw_pkg::EBSW_AREAS,
  // Code of the nine-cycle separate-bus setting
  parameter logic [ebsw_pkg::EBSW_CODE_W-1:0] SEP_NINE_CODE = 5'h15
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bclk,
  input wire logic area_select_config_hi,
  input wire logic area_select_config_lo,
  input wire logic strobe_style_select,
  input wire logic internal_ram_wait,
  input wire logic register_space_wait,
  input wire logic [NUM_AREAS-1:0] space_width_bits,
  input wire logic [NUM_AREAS-1:0] mux_bus_select,
  input wire logic [NUM_AREAS-1:0][ebsw_pkg::EBSW_CODE_W-1:0] wait_cycle_code,
  input wire logic req_valid,
  output logic req_ready,
  input wire ebsw_pkg::ebsw_kind_t req_kind,
  input wire logic [1:0] req_space,
  input wire logic [ebsw_pkg::EBSW_ADDR_W-1:0] req_addr,
  input wire logic req_write,
  input wire logic req_word,
  output logic resp_done,
  output logic resp_reserved,
  output logic [ebsw_pkg::EBSW_LOW_ADDR_W-1:0] ext_addr,
  output logic [ebsw_pkg::EBSW_PIN_W-1:0] area_pin,
  output logic read_n,
  output logic low_byte_store_n,
  output logic high_byte_store_n,
  output logic upper_lane_enable_n
);

  localparam int unsigned AW = ebsw_pkg::EBSW_ADDR_W;
  localparam int unsigned CW = ebsw_pkg::EBSW_CNT_W;
  localparam int unsigned PW = ebsw_pkg::EBSW_PIN_W;
  localparam int unsigned CFG_W = 5 + 2 * NUM_AREAS + NUM_AREAS * ebsw_pkg::EBSW_CODE_W;

  if (NUM_AREAS != ebsw_pkg::EBSW_AREAS)
  begin : g_bad_areas
    $error("ebsw_ctrl: NUM_AREAS must equal the four pin-shared areas");
  end

  typedef enum logic {EBSW_IDLE, EBSW_RUN} ebsw_st_t;

  typedef struct packed {
    logic busy;
    logic req_tgl;
    logic done;
    logic rsv;
    ebsw_pkg::ebsw_kind_t kind;
    logic [1:0] space;
    logic [AW-1:0] addr;
    logic write;
    logic word;
  } ebsw_ref_t;

  typedef struct packed {
    ebsw_st_t st;
    logic [CW-1:0] cnt;
    logic ack_tgl;
    logic rsv;
    logic ext;
    logic wr;
    logic wide;
    logic split;
    logic lane_e;
    logic lane_o;
    logic [NUM_AREAS-1:0] cs_n;
    logic [AW-1:0] addr;
    logic [PW-1:0] pin;
    logic rd_n;
    logic lo_n;
    logic hi_n;
    logic bhe_n;
  } ebsw_bus_t;

  ebsw_ref_t r_q;
  ebsw_ref_t r_d;
  ebsw_bus_t b_q;
  ebsw_bus_t b_d;

  logic ack_s;
  logic req_s;
  logic [CFG_W-1:0] cfg_s;
  logic [1:0] acfg;
  logic style;
  logic ramw;
  logic sfrw;
  logic [NUM_AREAS-1:0] width;
  logic [NUM_AREAS-1:0] muxsel;
  logic [NUM_AREAS-1:0][ebsw_pkg::EBSW_CODE_W-1:0] codes;
  logic start;

  // Configuration is sampled into the bus domain; changes mid-cycle are unsafe
  ebsw_sync #(.WIDTH(CFG_W)) u_cfg_sync (
    .clk(bclk),
    .arst_n(arst_n),
    .din({area_select_config_hi, area_select_config_lo, strobe_style_select,
          internal_ram_wait, register_space_wait, space_width_bits, mux_bus_select,
          wait_cycle_code}),
    .dout(cfg_s)
  );
  assign {acfg, style, ramw, sfrw, width, muxsel, codes} = cfg_s;

  ebsw_sync #(.WIDTH(1)) u_req_sync (
    .clk(bclk),
    .arst_n(arst_n),
    .din(r_q.req_tgl),
    .dout(req_s)
  );

  ebsw_sync #(.WIDTH(1)) u_ack_sync (
    .clk(ref_clk),
    .arst_n(arst_n),
    .din(b_q.ack_tgl),
    .dout(ack_s)
  );

  // Request side: fields stay frozen while busy so the bus domain may read them
  always_comb
  begin
    r_d = r_q;
    r_d.done = 1'b0;
    if (!r_q.busy && req_valid)
    begin
      r_d.busy = 1'b1;
      r_d.req_tgl = ~r_q.req_tgl;
      r_d.kind = req_kind;
      r_d.space = req_space;
      r_d.addr = req_addr;
      r_d.write = req_write;
      r_d.word = req_word;
    end
    else if (r_q.busy && (ack_s == r_q.req_tgl))
    begin
      r_d.busy = 1'b0;
      r_d.done = 1'b1;
      // Stable: the bus side holds it until the next request toggle
      r_d.rsv = b_q.rsv;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign req_ready = ~r_q.busy;
  assign resp_done = r_q.done;
  assign resp_reserved = r_q.rsv;

  assign start = (b_q.st == EBSW_IDLE) && (req_s != b_q.ack_tgl);

  // Bus side
  always_comb
  begin
    logic [CW:0] dec;
    logic [CW-1:0] ncyc;
    logic [2:0] nsel;
    b_d = b_q;
    dec = ebsw_pkg::ebsw_wait_decode(codes[r_q.space], muxsel[r_q.space], SEP_NINE_CODE);
    ncyc = ebsw_pkg::EBSW_ONE_CYC;
    nsel = ebsw_pkg::ebsw_sel_count(acfg);
    unique case (b_q.st)
      EBSW_IDLE:
      begin
        if (start)
        begin
          b_d.ext = (r_q.kind == ebsw_pkg::EBSW_KIND_EXT);
          b_d.rsv = 1'b0;
          if (r_q.kind == ebsw_pkg::EBSW_KIND_RAM)
            ncyc = ramw ? ebsw_pkg::EBSW_RAM_WAIT_CYC : ebsw_pkg::EBSW_RAM_CYC;
          else if (r_q.kind == ebsw_pkg::EBSW_KIND_SFR)
            ncyc = sfrw ? ebsw_pkg::EBSW_SFR_WAIT_CYC : ebsw_pkg::EBSW_SFR_CYC;
          else
          begin
            ncyc = dec[CW-1:0];
            b_d.rsv = dec[CW];
          end
          if (r_q.kind == ebsw_pkg::EBSW_KIND_EXT)
          begin
            // A new external access always carries its own address
            b_d.addr = r_q.addr;
            b_d.cs_n = '1;
            if ({1'b0, r_q.space} < nsel)
              b_d.cs_n[r_q.space] = 1'b0;
            b_d.wr = r_q.write;
            b_d.wide = width[r_q.space];
            b_d.split = strobe_style_select_eff(style, width[r_q.space]);
            b_d.lane_e = r_q.word | ~r_q.addr[0];
            b_d.lane_o = r_q.word | r_q.addr[0];
            b_d.bhe_n = ~(width[r_q.space] & ~b_d.split & b_d.lane_o);
            b_d.rd_n = r_q.write;
            b_d.lo_n = ~(r_q.write & (~b_d.split | b_d.lane_e));
            b_d.hi_n = ~(r_q.write & b_d.split & b_d.lane_o);
          end
          else
            b_d.cs_n = '1;
          if (ncyc == ebsw_pkg::EBSW_ONE_CYC)
            b_d.ack_tgl = ~b_q.ack_tgl;
          else
          begin
            b_d.st = EBSW_RUN;
            b_d.cnt = CW'(ncyc - ebsw_pkg::EBSW_ONE_CYC);
          end
        end
      end
      EBSW_RUN:
      begin
        if (b_q.cnt == ebsw_pkg::EBSW_ONE_CYC)
        begin
          // Strobes drop at the end of the cycle; select and address hold on
          b_d.rd_n = 1'b1;
          b_d.lo_n = 1'b1;
          b_d.hi_n = 1'b1;
          b_d.ack_tgl = ~b_q.ack_tgl;
          b_d.st = EBSW_IDLE;
        end
        else
          b_d.cnt = CW'(b_q.cnt - ebsw_pkg::EBSW_ONE_CYC);
      end
    endcase
    for (int p = 0; p < PW; p++)
    begin
      if ({1'b0, 2'(PW - 1 - p)} < nsel)
        b_d.pin[p] = b_d.cs_n[PW - 1 - p];
      else if (p == PW - 1)
        b_d.pin[p] = ~b_d.addr[AW - 1];
      else
        b_d.pin[p] = b_d.addr[AW - PW + p];
    end
  end

  // Split strobes only for a wide space with the style bit set
  function automatic logic strobe_style_select_eff(input logic sty, input logic wide);
    return sty & wide;
  endfunction : strobe_style_select_eff

  always_ff @(posedge bclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      b_q <= '0;
      b_q.st <= EBSW_IDLE;
      b_q.cs_n <= '1;
      b_q.pin <= '1;
      b_q.rd_n <= 1'b1;
      b_q.lo_n <= 1'b1;
      b_q.hi_n <= 1'b1;
      b_q.bhe_n <= 1'b1;
    end
    else
      b_q <= b_d;
  end

  assign ext_addr = b_q.addr[ebsw_pkg::EBSW_LOW_ADDR_W-1:0];
  assign area_pin = b_q.pin;
  assign read_n = b_q.rd_n;
  assign low_byte_store_n = b_q.lo_n;
  assign high_byte_store_n = b_q.hi_n;
  assign upper_lane_enable_n = b_q.bhe_n;

  AST_CS_AREA: assert property (@(posedge bclk) disable iff (!arst_n)
    (start && r_q.kind == ebsw_pkg::EBSW_KIND_EXT && acfg == ebsw_pkg::EBSW_ACFG_FOUR)
    |=> (!b_q.cs_n[$past(r_q.space)] && $countones(b_q.cs_n) == 3))
    else $error("area select does not match accessed area");

  AST_DIFF_AREA: assert property (@(posedge bclk) disable iff (!arst_n)
    (start && r_q.kind == ebsw_pkg::EBSW_KIND_EXT && acfg == ebsw_pkg::EBSW_ACFG_FOUR
     && b_q.cs_n[r_q.space] && !(&b_q.cs_n))
    |=> !$stable(b_q.cs_n))
    else $error("select did not move to the new area");

  AST_INT_HOLD: assert property (@(posedge bclk) disable iff (!arst_n)
    (start && r_q.kind != ebsw_pkg::EBSW_KIND_EXT) |=> ((&b_q.cs_n) && $stable(b_q.addr)))
    else $error("internal access disturbed address or left a select low");

  AST_SAME_AREA: assert property (@(posedge bclk) disable iff (!arst_n)
    (start && r_q.kind == ebsw_pkg::EBSW_KIND_EXT && !b_q.cs_n[r_q.space])
    |=> $stable(b_q.cs_n))
    else $error("select moved within the same area");

  AST_NO_ACCESS: assert property (@(posedge bclk) disable iff (!arst_n)
    (b_q.st == EBSW_IDLE && !start) |=> ($stable(b_q.cs_n) && $stable(b_q.addr)))
    else $error("idle cycle changed select or address");

  AST_AUTO_STYLE: assert property (@(posedge bclk) disable iff (!arst_n)
    (b_q.ext && !b_q.wide) |-> (!b_q.split && b_q.hi_n && b_q.bhe_n))
    else $error("narrow space used split strobes or upper lane");

  AST_SPLIT_WORD: assert property (@(posedge bclk) disable iff (!arst_n)
    (b_q.st == EBSW_RUN && b_q.ext && b_q.split && b_q.wr && b_q.lane_e && b_q.lane_o)
    |-> (!b_q.lo_n && !b_q.hi_n && b_q.rd_n))
    else $error("split word write lacks both store strobes");

  AST_ENABLE_ODD: assert property (@(posedge bclk) disable iff (!arst_n)
    (b_q.st == EBSW_RUN && b_q.wide && !b_q.split && b_q.lane_o && !b_q.lane_e)
    |-> (!b_q.bhe_n && b_q.addr[0]))
    else $error("odd byte access without upper lane enable");

  AST_RAM_LEN: assert property (@(posedge bclk) disable iff (!arst_n)
    (start && r_q.kind == ebsw_pkg::EBSW_KIND_RAM && ramw)
    |=> (b_q.ack_tgl == $past(b_q.ack_tgl)) ##1 (b_q.ack_tgl != $past(b_q.ack_tgl)))
    else $error("internal RAM wait cycle length wrong");

  AST_SFR_LEN: assert property (@(posedge bclk) disable iff (!arst_n)
    (start && r_q.kind == ebsw_pkg::EBSW_KIND_SFR && !sfrw)
    |=> (b_q.ack_tgl == $past(b_q.ack_tgl)) ##1 (b_q.ack_tgl != $past(b_q.ack_tgl)))
    else $error("register space cycle length wrong");

  AST_EXT_FOUR: assert property (@(posedge bclk) disable iff (!arst_n)
    (start && r_q.kind == ebsw_pkg::EBSW_KIND_EXT && !muxsel[r_q.space]
     && codes[r_q.space] == 5'h03)
    |=> (!b_q.lo_n || !b_q.hi_n || !b_q.rd_n)[*3]
    ##1 (b_q.rd_n && b_q.lo_n && b_q.hi_n && b_q.st == EBSW_IDLE))
    else $error("four-cycle external access has wrong strobe length");

endmodule : ebsw_ctrl
`default_nettype wire

// [verif/ebsw_ext_dev.sv]
// Purpose: Far-side bus device that records what one external cycle showed on the pins
// Assumes: Strobes and pins change on rising bclk and hold between edges
// Notes: Drives nothing back, since the block has no ready or data pins
`timescale 1ns/100ps
`default_nettype none
module ebsw_ext_dev (
  input wire logic bclk,
  input wire logic arst_n,
  input wire logic [19:0] ext_addr,
  input wire logic [3:0] area_pin,
  input wire logic read_n,
  input wire logic low_byte_store_n,
  input wire logic high_byte_store_n,
  input wire logic upper_lane_enable_n,
  output logic [3:0] seen_strb,
  output logic [3:0] seen_pin,
  output logic [19:0] seen_addr,
  output logic [3:0] low_len
);
  logic idle_q;
  logic idle;
  assign idle = read_n & low_byte_store_n & high_byte_store_n;
  always_ff @(posedge bclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idle_q <= 1'b1;
      seen_strb <= 4'hf;
      seen_pin <= 4'hf;
      seen_addr <= 20'h0;
      low_len <= 4'h0;
    end
    else
    begin
      idle_q <= idle;
      // Pins are latched on the first low sample, as a slow device would
      if (!idle && idle_q)
      begin
        seen_strb <= {read_n, low_byte_store_n, high_byte_store_n, upper_lane_enable_n};
        seen_pin <= area_pin;
        seen_addr <= ext_addr;
        low_len <= 4'h1;
      end
      else if (!idle)
        low_len <= low_len + 4'h1;
    end
  end
endmodule : ebsw_ext_dev
`default_nettype wire

// [verif/external_bus_strobe_wait_control_tb_top.sv]
// Purpose: Self-checking bench for selects, strobes and cycle lengths
// Assumes: bclk is exactly four ref_clk periods with a fixed offset
// Notes: Requests start at a fixed bclk phase so latency differences are exact
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module external_bus_strobe_wait_control_tb_top;
  logic ref_clk = 1'b0;
  logic bclk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] acfg = 2'h0;
  logic style = 1'b0;
  logic ram_w = 1'b0;
  logic reg_w = 1'b0;
  logic [3:0] wide = 4'h0;
  logic [3:0] mux = 4'h0;
  logic [3:0][4:0] wcode = {4{5'h01}};
  logic req_valid = 1'b0;
  ebsw_pkg::ebsw_kind_t req_kind = ebsw_pkg::EBSW_KIND_RAM;
  logic [1:0] req_space = 2'h0;
  logic [23:0] req_addr = 24'h0;
  logic req_write = 1'b0;
  logic req_word = 1'b0;
  logic req_ready, resp_done, resp_reserved, read_n, lo_n, hi_n, ule_n;
  logic [19:0] ext_addr, seen_addr;
  logic [3:0] area_pin, seen_strb, seen_pin, low_len;
  int n_mismatch = 0;
  int n_tests = 0;
  int lat, l0;
  logic [23:0] a;
  logic [4:0] sc [12] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0a, 5'h0b, 5'h0c,
    5'h13, 5'h14, 5'h15};
  int sn [12] = '{2, 3, 4, 5, 6, 7, 4, 5, 6, 6, 7, 9};
  logic [4:0] mc [7] = '{5'h0a, 5'h0b, 5'h0d, 5'h13, 5'h14, 5'h15, 5'h16};
  int mn [7] = '{4, 5, 7, 6, 7, 8, 9};

  initial forever #10 ref_clk = ~ref_clk;
  initial
  begin
    #13;
    forever #40 bclk = ~bclk;
  end

  ebsw_ctrl u_ebsw_ctrl (
    .ref_clk(ref_clk), .arst_n(arst_n), .bclk(bclk),
    .area_select_config_hi(acfg[1]), .area_select_config_lo(acfg[0]),
    .strobe_style_select(style), .internal_ram_wait(ram_w), .register_space_wait(reg_w),
    .space_width_bits(wide), .mux_bus_select(mux), .wait_cycle_code(wcode),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
    .req_space(req_space), .req_addr(req_addr), .req_write(req_write), .req_word(req_word),
    .resp_done(resp_done), .resp_reserved(resp_reserved), .ext_addr(ext_addr),
    .area_pin(area_pin), .read_n(read_n), .low_byte_store_n(lo_n),
    .high_byte_store_n(hi_n), .upper_lane_enable_n(ule_n));

  ebsw_ext_dev u_ebsw_ext_dev (
    .bclk(bclk), .arst_n(arst_n), .ext_addr(ext_addr), .area_pin(area_pin),
    .read_n(read_n), .low_byte_store_n(lo_n), .high_byte_store_n(hi_n),
    .upper_lane_enable_n(ule_n), .seen_strb(seen_strb), .seen_pin(seen_pin),
    .seen_addr(seen_addr), .low_len(low_len));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Configuration only moves while idle; the wait covers its two-flop crossing
  task automatic settle();
    repeat (20) @(negedge ref_clk);
  endtask : settle

  task automatic acc(input ebsw_pkg::ebsw_kind_t k, input logic [1:0] s, input logic [23:0] ad,
    input logic w, input logic wd);
    int n;
    @(posedge bclk);
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_kind = k;
    req_space = s;
    req_addr = ad;
    req_write = w;
    req_word = wd;
    @(negedge ref_clk);
    req_valid = 1'b0;
    `CHECK(req_ready, 1'b0)
    n = 0;
    while (resp_done !== 1'b1 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    lat = n;
    if (n >= 300)
    begin
      n_mismatch++;
      report_and_stop();
    end
    else
      repeat (2) @(negedge ref_clk);
  endtask : acc

  function automatic logic [3:0] exp_pin(input logic [1:0] c, input logic [1:0] s,
    input logic [23:0] ad);
    logic [3:0] r;
    int n;
    n = (c == 2'h3) ? 4 : int'(c);
    r = {~ad[23], ad[22:20]};
    for (int p = 0; p < 4; p++)
      if (3 - p < n)
        r[p] = (s != 2'(3 - p));
    return r;
  endfunction : exp_pin

  task automatic strb(input logic [1:0] s, input logic a0, input logic w, input logic wd,
    input logic [3:0] e, input logic [3:0] m);
    acc(ebsw_pkg::EBSW_KIND_EXT, s, {23'h012340, a0}, w, wd);
    `CHECK(seen_strb & m, e & m)
  endtask : strb

  task automatic wt(input logic [4:0] code, input logic mx, input int n, input logic rsv);
    wcode[2] = code;
    mux[2] = mx;
    settle();
    acc(ebsw_pkg::EBSW_KIND_EXT, 2'h2, 24'h0a5500, 1'b0, 1'b0);
    `CHECK(lat, l0 + 4 * (n - 1))
    `CHECK(low_len, 4'(n - 1))
    `CHECK(resp_reserved, rsv)
  endtask : wt

  initial
  begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    `CHECK(area_pin, 4'hf)
    `CHECK({read_n, lo_n, hi_n, ule_n}, 4'hf)
    settle();
    acc(ebsw_pkg::EBSW_KIND_RAM, 2'h0, 24'h000010, 1'b0, 1'b0);
    l0 = lat;
    ram_w = 1'b1;
    settle();
    acc(ebsw_pkg::EBSW_KIND_RAM, 2'h0, 24'h000010, 1'b1, 1'b0);
    `CHECK(lat, l0 + 4)
    acc(ebsw_pkg::EBSW_KIND_SFR, 2'h0, 24'h000020, 1'b0, 1'b0);
    `CHECK(lat, l0 + 4)
    reg_w = 1'b1;
    settle();
    acc(ebsw_pkg::EBSW_KIND_SFR, 2'h0, 24'h000020, 1'b1, 1'b0);
    `CHECK(lat, l0 + 8)
    for (int c = 0; c < 4; c++)
    begin
      acfg = 2'(c);
      settle();
      for (int s = 0; s < 4; s++)
      begin
        a = 24'(s * 24'h350000 + c * 24'h01234 + 24'h900000);
        acc(ebsw_pkg::EBSW_KIND_EXT, 2'(s), a, 1'b1, 1'b0);
        `CHECK(seen_pin, exp_pin(2'(c), 2'(s), a))
        `CHECK(seen_addr, a[19:0])
      end
    end
    acc(ebsw_pkg::EBSW_KIND_EXT, 2'h1, 24'h100100, 1'b0, 1'b0);
    acc(ebsw_pkg::EBSW_KIND_EXT, 2'h1, 24'h100200, 1'b0, 1'b0);
    `CHECK(seen_pin, 4'hb)
    `CHECK(seen_addr, 20'h00200)
    repeat (40) @(negedge ref_clk);
    `CHECK(area_pin, 4'hb)
    `CHECK(ext_addr, 20'h00200)
    acc(ebsw_pkg::EBSW_KIND_SFR, 2'h0, 24'h000030, 1'b0, 1'b0);
    `CHECK(area_pin, 4'hf)
    `CHECK(ext_addr, 20'h00200)
    wide = 4'h1;
    style = 1'b1;
    settle();
    strb(2'h0, 1'b0, 1'b0, 1'b0, 4'h6, 4'he);
    strb(2'h0, 1'b0, 1'b1, 1'b0, 4'ha, 4'he);
    strb(2'h0, 1'b1, 1'b1, 1'b0, 4'hc, 4'he);
    strb(2'h0, 1'b0, 1'b1, 1'b1, 4'h8, 4'he);
    strb(2'h1, 1'b0, 1'b1, 1'b0, 4'hb, 4'hf);
    strb(2'h1, 1'b1, 1'b0, 1'b0, 4'h7, 4'hf);
    style = 1'b0;
    settle();
    strb(2'h0, 1'b1, 1'b1, 1'b0, 4'ha, 4'hd);
    strb(2'h0, 1'b1, 1'b0, 1'b0, 4'h6, 4'hd);
    strb(2'h0, 1'b0, 1'b1, 1'b0, 4'hb, 4'hd);
    strb(2'h0, 1'b0, 1'b0, 1'b0, 4'h7, 4'hd);
    strb(2'h0, 1'b0, 1'b1, 1'b1, 4'ha, 4'hd);
    strb(2'h0, 1'b0, 1'b0, 1'b1, 4'h6, 4'hd);
    for (int i = 0; i < 12; i++)
      wt(sc[i], 1'b0, sn[i], 1'b0);
    for (int i = 0; i < 7; i++)
      wt(mc[i], 1'b1, mn[i], 1'b0);
    wt(5'h00, 1'b0, 9, 1'b1);
    wt(5'h01, 1'b1, 9, 1'b1);
    report_and_stop();
  end
endmodule : external_bus_strobe_wait_control_tb_top
`default_nettype wire
